// File: spims_consts.vh
// Constants for the serial peripheral port
`ifndef SPIMS_CONSTS_VH
`define SPIMS_CONSTS_VH
`define SPIMS_MODE_CPOL_BIT    1
`define SPIMS_MODE_CPHA_BIT    0
`define SPIMS_BITS_PER_BYTE    4'h8
`define SPIMS_BIT_CNT_RESET    4'h0
`define SPIMS_DATA_RESET       8'h00
`define SPIMS_HALF_DIV2        7'h01
`define SPIMS_HALF_DIV4        7'h02
`define SPIMS_HALF_DIV8        7'h04
`define SPIMS_HALF_DIV16       7'h08
`define SPIMS_HALF_DIV32       7'h10
`define SPIMS_HALF_DIV64       7'h20
`define SPIMS_HALF_DIV128      7'h40
`endif

// File: spims_clkdiv.v
// Master clock divider producing half-period enable pulses
`timescale 1ns/1ns
`include "spims_consts.vh"
module spims_clkdiv (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst,
    // Control
    input  wire       run,
    input  wire [1:0] sck_divider_select,
    input  wire       double_speed,
    // Half-period enable pulse
    output reg        half_tick_q
);
    reg  [6:0] cnt_q;
    wire [6:0] half_len;

    function [6:0] spims_half;
        input [1:0] sel;
        input       dbl;
        begin
            case ({dbl, sel})
                3'b000:  spims_half = `SPIMS_HALF_DIV4;
                3'b001:  spims_half = `SPIMS_HALF_DIV16;
                3'b010:  spims_half = `SPIMS_HALF_DIV64;
                3'b011:  spims_half = `SPIMS_HALF_DIV128;
                3'b100:  spims_half = `SPIMS_HALF_DIV2;
                3'b101:  spims_half = `SPIMS_HALF_DIV8;
                3'b110:  spims_half = `SPIMS_HALF_DIV32;
                default: spims_half = `SPIMS_HALF_DIV64;
            endcase
        end
    endfunction

    assign half_len = spims_half(sck_divider_select, double_speed);

    always @(posedge mclk) begin
        if (rst || !run) begin
            cnt_q       <= 7'h00;
            half_tick_q <= 1'b0;
        end else if (cnt_q + 7'h01 >= half_len) begin
            cnt_q       <= 7'h00;
            half_tick_q <= 1'b1;
        end else begin
            cnt_q       <= cnt_q + 7'h01;
            half_tick_q <= 1'b0;
        end
    end
endmodule // spims_clkdiv

// File: spims_port.v
// Serial peripheral port, master or slave, byte exchange engine
`timescale 1ns/1ns
`include "spims_consts.vh"
module spims_port (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst,
    // Configuration
    input  wire       enable,
    input  wire       master_select,
    input  wire       master_clear_ack,
    input  wire       double_speed,
    input  wire       lsb_first_select,
    input  wire [1:0] mode,
    input  wire [1:0] sck_divider_select,
    input  wire       ss_is_output,
    // Software data access
    input  wire       data_wr,
    input  wire [7:0] data_wdata,
    input  wire       data_rd,
    input  wire       status_rd,
    input  wire       irq_ack,
    // Status and data
    output reg  [7:0] rx_data_q,
    output reg        transfer_done_flag_q,
    output reg        write_collision_flag_q,
    output reg        master_active_q,
    output reg        dma_req_q,
    // Serial pins
    input  wire       sck_in,
    output reg        sck_out_q,
    output reg        sck_oe_q,
    input  wire       mosi_in,
    output reg        mosi_out_q,
    output reg        mosi_oe_q,
    input  wire       miso_in,
    output reg        miso_out_q,
    output reg        miso_oe_q,
    input  wire       ss_n_in,
    output reg        ss_oe_q
);
    localparam ST_IDLE  = 2'b00;
    localparam ST_LEAD  = 2'b01;
    localparam ST_TRAIL = 2'b10;

    reg  [1:0] st_q;
    reg  [7:0] shift_q;
    reg  [3:0] bit_cnt_q;
    reg        busy_q;
    reg        sck_prev_q;
    reg        ss_prev_q;
    reg        stat_armed_q;
    wire       half_tick;
    wire       cpol;
    wire       cpha;
    wire       is_master;
    wire       sck_idle_lvl;
    wire       lead_edge;
    wire       trail_edge;
    wire       samp_edge;
    wire       setup_edge;
    wire       slave_sel;
    wire       out_bit;
    wire       ss_lost;
    wire [7:0] shift_in;
    wire       in_bit;
    wire       last_bit;
    wire       byte_end;
    wire       m_finish;
    wire       xfer_busy;
    wire       data_acc;

    assign cpol      = mode[`SPIMS_MODE_CPOL_BIT];
    assign cpha      = mode[`SPIMS_MODE_CPHA_BIT];
    assign is_master = enable && master_active_q;
    assign data_acc  = data_wr || data_rd;

    spims_clkdiv u_div (
        .mclk               (mclk),
        .rst                (rst),
        .run                (is_master && busy_q),
        .sck_divider_select (sck_divider_select),
        .double_speed       (double_speed),
        .half_tick_q        (half_tick)
    );

    assign out_bit  = lsb_first_select ? shift_q[0] : shift_q[7];
    assign in_bit   = is_master ? miso_in : mosi_in;
    assign shift_in = lsb_first_select ? {in_bit, shift_q[7:1]}
                                       : {shift_q[6:0], in_bit};

    // Edges of the serial clock: driven ones in master, sampled in slave
    assign sck_idle_lvl = cpol;
    assign slave_sel    = enable && !master_active_q && !ss_n_in;
    assign lead_edge    = is_master ? (busy_q && half_tick && st_q == ST_LEAD)
                        : (slave_sel && sck_prev_q == sck_idle_lvl
                           && sck_in != sck_idle_lvl);
    assign trail_edge   = is_master ? (busy_q && half_tick && st_q == ST_TRAIL)
                        : (slave_sel && sck_prev_q != sck_idle_lvl
                           && sck_in == sck_idle_lvl);
    assign samp_edge    = cpha ? trail_edge : lead_edge;
    assign setup_edge   = cpha ? lead_edge : trail_edge;
    assign last_bit     = (bit_cnt_q + 4'h1) == `SPIMS_BITS_PER_BYTE;
    assign byte_end     = samp_edge && last_bit;
    assign m_finish     = is_master && trail_edge
                          && (byte_end || bit_cnt_q == `SPIMS_BITS_PER_BYTE);
    assign xfer_busy    = is_master ? busy_q
                        : (slave_sel && bit_cnt_q != `SPIMS_BIT_CNT_RESET);
    assign ss_lost      = enable && master_active_q && !ss_is_output && !ss_n_in;

    always @(posedge mclk) begin
        if (rst) begin
            st_q                   <= ST_IDLE;
            shift_q                <= `SPIMS_DATA_RESET;
            bit_cnt_q              <= `SPIMS_BIT_CNT_RESET;
            busy_q                 <= 1'b0;
            sck_prev_q             <= 1'b0;
            ss_prev_q              <= 1'b1;
            stat_armed_q           <= 1'b0;
            rx_data_q              <= `SPIMS_DATA_RESET;
            transfer_done_flag_q   <= 1'b0;
            write_collision_flag_q <= 1'b0;
            master_active_q        <= 1'b0;
            dma_req_q              <= 1'b0;
            sck_out_q              <= 1'b0;
            mosi_out_q             <= 1'b0;
            miso_out_q             <= 1'b0;
        end else begin
            sck_prev_q <= sck_in;
            ss_prev_q  <= ss_n_in;
            dma_req_q  <= 1'b0;
            if (master_clear_ack) begin
                master_active_q <= master_select;
            end else if (ss_lost) begin
                master_active_q <= 1'b0;
            end
            if (status_rd) begin
                stat_armed_q <= transfer_done_flag_q || write_collision_flag_q;
            end else if (data_acc) begin
                stat_armed_q <= 1'b0;
            end
            if ((stat_armed_q && data_acc) || irq_ack) begin
                transfer_done_flag_q <= 1'b0;
            end
            if (stat_armed_q && data_acc) begin
                write_collision_flag_q <= 1'b0;
            end
            if (data_wr && enable && xfer_busy) begin
                write_collision_flag_q <= 1'b1;
            end
            if (!enable) begin
                busy_q    <= 1'b0;
                st_q      <= ST_IDLE;
                bit_cnt_q <= `SPIMS_BIT_CNT_RESET;
                sck_out_q <= cpol;
            end else if (ss_lost) begin
                busy_q               <= 1'b0;
                st_q                 <= ST_IDLE;
                bit_cnt_q            <= `SPIMS_BIT_CNT_RESET;
                transfer_done_flag_q <= 1'b1;
                sck_out_q            <= cpol;
            end else if (!master_active_q && ss_n_in && !ss_prev_q) begin
                busy_q    <= 1'b0;
                bit_cnt_q <= `SPIMS_BIT_CNT_RESET;
            end else if (data_wr && !xfer_busy) begin
                shift_q   <= data_wdata;
                bit_cnt_q <= `SPIMS_BIT_CNT_RESET;
                busy_q    <= is_master;
                st_q      <= is_master ? ST_LEAD : ST_IDLE;
                sck_out_q <= cpol;
                if (!cpha) begin
                    mosi_out_q <= lsb_first_select ? data_wdata[0] : data_wdata[7];
                    miso_out_q <= lsb_first_select ? data_wdata[0] : data_wdata[7];
                end
            end else begin
                if (is_master && !busy_q) begin
                    sck_out_q <= cpol;
                end
                if (is_master && busy_q && half_tick) begin
                    sck_out_q <= ~sck_out_q;
                    case (st_q)
                        ST_LEAD:  st_q <= ST_TRAIL;
                        ST_TRAIL: st_q <= m_finish ? ST_IDLE : ST_LEAD;
                        default:  st_q <= ST_IDLE;
                    endcase
                end
                if (samp_edge) begin
                    shift_q   <= shift_in;
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
                if (setup_edge) begin
                    mosi_out_q <= out_bit;
                    miso_out_q <= out_bit;
                end
                if (byte_end) begin
                    rx_data_q <= shift_in;
                end
                if (byte_end && !is_master) begin
                    bit_cnt_q            <= `SPIMS_BIT_CNT_RESET;
                    transfer_done_flag_q <= 1'b1;
                    dma_req_q            <= 1'b1;
                end
                if (m_finish) begin
                    busy_q               <= 1'b0;
                    bit_cnt_q            <= `SPIMS_BIT_CNT_RESET;
                    transfer_done_flag_q <= 1'b1;
                end
            end
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            miso_oe_q <= 1'b0;
            mosi_oe_q <= 1'b0;
            sck_oe_q  <= 1'b0;
            ss_oe_q   <= 1'b0;
        end else begin
            miso_oe_q <= enable && !master_active_q && !ss_n_in;
            mosi_oe_q <= enable && master_active_q;
            sck_oe_q  <= enable && master_active_q;
            ss_oe_q   <= enable && master_active_q && ss_is_output;
        end
    end

endmodule // spims_port

// File: spims_port_checker.sv
// Concurrent checks on the serial peripheral port
`timescale 1ns/1ns
module spims_port_checker (
    // Clock and reset
    input wire       mclk,
    input wire       rst,
    // Configuration and software strobes
    input wire       enable,
    input wire       ss_is_output,
    input wire       data_wr,
    input wire       irq_ack,
    // Status
    input wire       master_active_q,
    input wire       transfer_done_flag_q,
    input wire       write_collision_flag_q,
    input wire       dma_req_q,
    // Pins
    input wire       ss_n_in,
    input wire       sck_oe_q,
    input wire       mosi_oe_q,
    input wire       miso_oe_q,
    input wire       ss_oe_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_miso_in; (enable && master_active_q)[*3] |-> !miso_oe_q; endproperty
    a_miso_in: assert property (p_miso_in) else $error("miso driven as master");
    property p_slave_pins; (enable && !master_active_q)[*3] |-> !(sck_oe_q || mosi_oe_q || ss_oe_q);
    endproperty
    a_slave_pins: assert property (p_slave_pins) else $error("slave pin driven");
    property p_ss_free; (master_active_q && !ss_is_output)[*2] |-> !ss_oe_q; endproperty
    a_ss_free: assert property (p_ss_free) else $error("select driven");
    property p_no_dma; master_active_q && $past(master_active_q) |-> !dma_req_q; endproperty
    a_no_dma: assert property (p_no_dma) else $error("dma request as master");
    property p_idle_miso; (enable && !master_active_q && ss_n_in)[*3] |-> !miso_oe_q; endproperty
    a_idle_miso: assert property (p_idle_miso) else $error("miso driven while idle");
    property p_loss; enable && master_active_q && !ss_is_output && !ss_n_in
        |-> ##[1:5] (!master_active_q && transfer_done_flag_q); endproperty
    a_loss: assert property (p_loss) else $error("master mode not lost");
    property p_ack; transfer_done_flag_q && irq_ack |=> ##[0:1] !transfer_done_flag_q; endproperty
    a_ack: assert property (p_ack) else $error("done flag kept after ack");
    property p_wcol; $rose(write_collision_flag_q) |-> $past(data_wr) || $past(data_wr, 2);
    endproperty
    a_wcol: assert property (p_wcol) else $error("collision without write");
endmodule // spims_port_checker

bind spims_port spims_port_checker chk_u (.mclk(mclk), .rst(rst), .enable(enable),
    .ss_is_output(ss_is_output), .data_wr(data_wr), .irq_ack(irq_ack),
    .master_active_q(master_active_q), .transfer_done_flag_q(transfer_done_flag_q),
    .write_collision_flag_q(write_collision_flag_q), .dma_req_q(dma_req_q),
    .ss_n_in(ss_n_in), .sck_oe_q(sck_oe_q), .mosi_oe_q(mosi_oe_q), .miso_oe_q(miso_oe_q),
    .ss_oe_q(ss_oe_q));

// File: spims_far_slave.sv
// Far-side serial slave answering the port in master mode
`timescale 1ns/1ns
module spims_far_slave (
    // Serial pins
    input  wire       sck,
    input  wire       ss_n,
    input  wire       mosi,
    output reg        miso,
    // Setup and result
    input  wire [1:0] mode,
    input  wire       lsb_first_select,
    input  wire [7:0] tx_byte,
    output reg  [7:0] rx_byte
);
    integer n;
    function bsel(input [7:0] v, input integer i);
        bsel = lsb_first_select ? v[i] : v[7 - i];
    endfunction
    initial begin
        miso = 1'b0;
        n = 0;
        rx_byte = 8'h00;
    end
    always @(negedge ss_n) begin
        n = 0;
        miso = bsel(tx_byte, 0);
    end
    always @(posedge ss_n) miso = ~miso;
    always @(sck) if (!ss_n) begin
        if ((sck !== mode[1]) == !mode[0]) begin
            rx_byte = lsb_first_select ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
            n = n + 1;
        end else if (n < 8) miso = bsel(tx_byte, n);
    end
endmodule // spims_far_slave

// File: spims_tb.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/1ns
module testbench;
    localparam [63:0] DIVS = 64'h4020080280401004;
    reg        mclk = 1'b0, rst = 1'b1, enable = 1'b0, master_select = 1'b0;
    reg        master_clear_ack = 1'b0, double_speed = 1'b0, lsb_first_select = 1'b0;
    reg  [1:0] mode = 2'h0, sck_divider_select = 2'h0;
    reg        ss_is_output = 1'b0, data_wr = 1'b0, data_rd = 1'b0, status_rd = 1'b0;
    reg        irq_ack = 1'b0, bsck = 1'b0, bmosi = 1'b0, ss_n = 1'b1;
    reg  [7:0] data_wdata = 8'h00, ptx = 8'h00, smi = 8'h00;
    integer    miscompares = 0, samples_checked = 0, cyc = 0, dma_cnt = 0;
    wire [7:0] rx_data_q, prx;
    wire       done, wcol, mact, dma, sck_o, sck_e, mosi_o, mosi_e, miso_o, miso_e, miso_p, ss_oe;
    wire       sck_w = sck_e ? sck_o : bsck;
    wire       mosi_w = mosi_e ? mosi_o : bmosi;
    wire       miso_w = miso_e ? miso_o : miso_p;
    always #2 mclk = ~mclk;
    spims_port dut_u (.mclk(mclk), .rst(rst), .enable(enable), .master_select(master_select),
        .master_clear_ack(master_clear_ack), .double_speed(double_speed),
        .lsb_first_select(lsb_first_select), .mode(mode), .sck_divider_select(sck_divider_select),
        .ss_is_output(ss_is_output), .data_wr(data_wr), .data_wdata(data_wdata),
        .data_rd(data_rd), .status_rd(status_rd), .irq_ack(irq_ack), .rx_data_q(rx_data_q),
        .transfer_done_flag_q(done), .write_collision_flag_q(wcol), .master_active_q(mact),
        .dma_req_q(dma), .sck_in(sck_w), .sck_out_q(sck_o), .sck_oe_q(sck_e), .mosi_in(mosi_w),
        .mosi_out_q(mosi_o), .mosi_oe_q(mosi_e), .miso_in(miso_w), .miso_out_q(miso_o),
        .miso_oe_q(miso_e), .ss_n_in(ss_n), .ss_oe_q(ss_oe));
    spims_far_slave far_u (.sck(sck_w), .ss_n(ss_n), .mosi(mosi_w), .miso(miso_p), .mode(mode),
        .lsb_first_select(lsb_first_select), .tx_byte(ptx), .rx_byte(prx));
    task tk(input integer n); repeat (n) @(negedge mclk); endtask
    task chk(input [7:0] got, input [7:0] exp); begin
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected %0t got %h expected %h", $time, got, exp);
        end
    end endtask
    task conclude; begin
        if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    end endtask
    task wr(input [7:0] d); begin
        data_wdata = d;
        data_wr = 1'b1;
        tk(1);
        data_wr = 1'b0;
    end endtask
    task wdone; integer k; begin
        for (k = 0; k < 3000 && done !== 1'b1; k = k + 1) tk(1);
        chk({7'h00, done}, 8'h01);
    end endtask
    task clr; begin
        status_rd = 1'b1;
        tk(1);
        status_rd = 1'b0;
        data_rd = 1'b1;
        tk(1);
        data_rd = 1'b0;
        tk(1);
    end endtask
    task ack; begin
        irq_ack = 1'b1;
        tk(1);
        irq_ack = 1'b0;
        tk(1);
    end endtask
    task t_master; integer i, c, r1, r2; reg pv; begin
        master_select = 1'b1;
        ss_is_output = 1'b1;
        master_clear_ack = 1'b1;
        tk(1);
        master_clear_ack = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            {double_speed, sck_divider_select} = i[2:0];
            mode = i[1:0];
            lsb_first_select = i[0];
            ptx = 8'hA5 ^ i[7:0];
            tk(2);
            ss_n = 1'b0;
            wr(8'h3C + i[7:0]);
            c = 0;
            r1 = 0;
            r2 = 0;
            pv = sck_o;
            while (done !== 1'b1 && c < 3000) begin
                tk(1);
                c = c + 1;
                if (sck_o === 1'b1 && pv === 1'b0 && r1 != 0 && r2 == 0) r2 = c;
                if (sck_o === 1'b1 && pv === 1'b0 && r1 == 0) r1 = c;
                pv = sck_o;
            end
            ss_n = 1'b1;
            chk({7'h00, done}, 8'h01);
            chk(r2[7:0] - r1[7:0], DIVS[i * 8 +: 8]);
            chk(prx, 8'h3C + i[7:0]);
            chk(rx_data_q, ptx);
            chk({7'h00, sck_o}, {7'h00, mode[1]});
            clr;
            chk({7'h00, done}, 8'h00);
        end
    end endtask
    task t_collide; begin
        {double_speed, sck_divider_select} = 3'h3;
        ss_n = 1'b0;
        wr(8'h5A);
        tk(40);
        wr(8'hFF);
        wdone;
        ss_n = 1'b1;
        chk(prx, 8'h5A);
        chk({7'h00, wcol}, 8'h01);
        ack;
        chk({7'h00, done}, 8'h00);
        clr;
        chk({7'h00, wcol}, 8'h00);
    end endtask
    task t_loss; begin
        ss_is_output = 1'b0;
        tk(4);
        ss_n = 1'b0;
        tk(6);
        chk({6'h00, mact, done}, 8'h01);
        ss_n = 1'b1;
        ack;
        master_select = 1'b0;
        master_clear_ack = 1'b1;
        tk(1);
        master_clear_ack = 1'b0;
    end endtask
    task sbyte(input [7:0] mo, input integer nb); integer b; begin
        for (b = 0; b < nb; b = b + 1) begin
            bmosi = mo[7 - b];
            tk(4);
            smi = {smi[6:0], miso_w};
            bsck = 1'b1;
            tk(4);
            bsck = 1'b0;
        end
    end endtask
    task t_slave; integer d0; begin
        mode = 2'h0;
        lsb_first_select = 1'b0;
        wr(8'hC3);
        tk(4);
        chk({7'h00, miso_e}, 8'h00);
        ss_n = 1'b0;
        sbyte(8'h96, 3);
        ss_n = 1'b1;
        bmosi = ~bmosi;
        tk(6);
        chk({7'h00, done}, 8'h00);
        wr(8'hC3);
        tk(4);
        ss_n = 1'b0;
        d0 = dma_cnt;
        sbyte(8'h96, 8);
        wdone;
        chk(rx_data_q, 8'h96);
        chk(smi, 8'hC3);
        d0 = dma_cnt - d0;
        chk(d0[7:0], 8'h01);
        ack;
        sbyte(8'h69, 8);
        wdone;
        ss_n = 1'b1;
        chk(rx_data_q, 8'h69);
    end endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (dma === 1'b1) dma_cnt <= dma_cnt + 1;
        if (cyc == 30000) begin
            miscompares = miscompares + 1;
            conclude;
        end
    end
    initial begin
        tk(6);
        rst = 1'b0;
        enable = 1'b1;
        tk(2);
        t_master;
        t_collide;
        t_loss;
        t_slave;
        conclude;
    end
endmodule // testbench
